// ---- bridge_control.sv ----
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module bridge_control (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       strap_variant_i,
  input  wire logic       logic_supply_ok_i,
  input  wire logic [1:0] mode_strap_i,
  input  wire logic       low_power_request_n_i,
  input  wire logic       disable_i,
  input  wire logic       input_a_i,
  input  wire logic       input_b_i,
  input  wire logic [1:0] overcurrent_trip_i,
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_write_i,
  input  wire logic       reg_read_i,
  output logic      [7:0] reg_rdata_o,
  output logic            output_a_o,
  output logic            output_a_oe_o,
  output logic            output_b_o,
  output logic            output_b_oe_o
);

  logic       rst_meta_q;
  logic       rst_sync_q;
  logic [9:0] pin_meta_q;
  logic [9:0] pin_sync_q;
  logic       strap_var_q;
  logic       supply_q;
  logic       awake_q;
  logic       disable_q;
  logic [1:0] strap_q;
  logic [1:0] trip_q;
  logic       in_a_q;
  logic       in_b_q;
  logic       supply_seen_q;
  logic       disable_prev_q;
  logic       awake_prev_q;
  logic [1:0] mode_field_q;
  logic [1:0] hiz_bits_q;
  logic [1:0] active_mode_q;
  logic [1:0] level_d;
  logic [1:0] drive_d;
  logic [1:0] hiz_eff;
  logic       disable_fall;
  logic       strap_capture;

  // Asynchronous assert, synchronous release keeps all state leaving reset together.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // All pins except the register port are asynchronous to the clock and pass two flip-flops.
  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pin_meta_q <= 10'h000;
      pin_sync_q <= 10'h000;
    end else begin
      pin_meta_q <= {strap_variant_i, logic_supply_ok_i, mode_strap_i, low_power_request_n_i,
                     disable_i, overcurrent_trip_i, input_a_i, input_b_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign {strap_var_q, supply_q, strap_q, awake_q, disable_q, trip_q, in_a_q, in_b_q} = pin_sync_q;

  // Edges come from the synchronised copies, so a pin pulse shorter than a clock may be missed.
  assign disable_fall  = disable_prev_q && !disable_q;
  assign strap_capture = supply_q && ((!supply_seen_q) || (awake_q && !awake_prev_q));

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      disable_prev_q <= 1'b0;
      awake_prev_q   <= 1'b0;
      supply_seen_q  <= 1'b0;
    end else begin
      disable_prev_q <= disable_q;
      awake_prev_q   <= awake_q;
      supply_seen_q  <= supply_seen_q | supply_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      mode_field_q <= bridge_pkg::MODE_RESET;
      hiz_bits_q   <= bridge_pkg::HIZ_RESET;
    end else if (reg_write_i) begin
      if (reg_addr_i == bridge_pkg::ADDR_FIRST_CTRL) begin
        mode_field_q <= reg_wdata_i[bridge_pkg::MODE_LSB +: 2];
      end
      if (reg_addr_i == bridge_pkg::ADDR_THIRD_CTRL) begin
        hiz_bits_q <= {reg_wdata_i[bridge_pkg::HIZ_B_BIT], reg_wdata_i[bridge_pkg::HIZ_A_BIT]};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      active_mode_q <= bridge_pkg::MODE_RESET;
    end else if (strap_var_q) begin
      if (strap_capture) begin
        unique case (strap_q)
          bridge_pkg::STRAP_LOW:  active_mode_q <= bridge_pkg::MODE_PHASE_ENABLE;
          bridge_pkg::STRAP_HIGH: active_mode_q <= bridge_pkg::MODE_PWM;
          default:                active_mode_q <= bridge_pkg::MODE_INDEPENDENT;
        endcase
      end
    end else if (disable_fall) begin
      // Latching only on the falling edge keeps a mode field write from disturbing a driving bridge.
      active_mode_q <= mode_field_q;
    end
  end

  // The strap variant ignores the per-output bits entirely.
  assign hiz_eff = strap_var_q ? 2'h0 : hiz_bits_q;

  output_decode u_decode (
    .mode_i     (active_mode_q),
    .awake_i    (awake_q),
    .disable_i  (disable_q),
    .input_a_i  (in_a_q),
    .input_b_i  (in_b_q),
    .hiz_bits_i (hiz_eff),
    .trip_i     (trip_q),
    .level_o    (level_d),
    .drive_o    (drive_d)
  );

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      output_a_o    <= 1'b0;
      output_b_o    <= 1'b0;
      output_a_oe_o <= 1'b0;
      output_b_oe_o <= 1'b0;
    end else begin
      output_a_o    <= level_d[0];
      output_b_o    <= level_d[1];
      output_a_oe_o <= drive_d[0];
      output_b_oe_o <= drive_d[1];
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_read_i) begin
      // Data stand for one cycle only; the idle value of zero keeps the bus quiet between reads.
      unique case (reg_addr_i)
        bridge_pkg::ADDR_FIRST_CTRL: reg_rdata_o <= {6'h00, mode_field_q};
        bridge_pkg::ADDR_THIRD_CTRL: reg_rdata_o <= {6'h00, hiz_bits_q};
        bridge_pkg::ADDR_STATUS:     reg_rdata_o <= {6'h00, active_mode_q};
        default:                     reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  mode_reset_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    $rose(rst_sync_q) |-> active_mode_q == bridge_pkg::MODE_RESET)
    else $error("Active mode not at reset value.");

  mode_hold_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (!strap_var_q && !disable_fall) |=> $stable(active_mode_q))
    else $error("Active mode changed without a disable falling edge.");

  mode_latch_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (!strap_var_q && disable_fall) |=> active_mode_q == $past(mode_field_q))
    else $error("Mode field not latched on disable fall.");

  strap_hold_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (strap_var_q && !strap_capture) |=> $stable(active_mode_q))
    else $error("Strap mode changed outside capture.");

  strap_supply_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    !supply_q |-> !strap_capture)
    else $error("Strap captured before logic supply.");

  sleep_hiz_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (!awake_q || disable_q) |=> !output_a_oe_o && !output_b_oe_o)
    else $error("Outputs driven while asleep or disabled.");

  pwm_brake_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (awake_q && !disable_q && active_mode_q == bridge_pkg::MODE_PWM && in_a_q && in_b_q)
    |=> output_a_oe_o && output_b_oe_o && output_a_o && output_b_o)
    else $error("PWM brake state wrong.");

  indep_trip_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (awake_q && !disable_q && active_mode_q == bridge_pkg::MODE_INDEPENDENT && trip_q == 2'h1
     && !hiz_eff[1]) |=> !output_a_oe_o && output_b_oe_o && output_b_o == $past(in_b_q))
    else $error("Trip isolation wrong.");

  phase_low_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (awake_q && !disable_q && active_mode_q == bridge_pkg::MODE_PHASE_ENABLE && !in_a_q)
    |=> output_a_o && output_b_o && output_a_oe_o && output_b_oe_o)
    else $error("Phase/enable low state wrong.");

  off_mode_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    active_mode_q == bridge_pkg::MODE_INPUTS_OFF |=> !output_a_oe_o && !output_b_oe_o)
    else $error("Outputs driven in off mode.");

  phase_fwd_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (awake_q && !disable_q && active_mode_q == bridge_pkg::MODE_PHASE_ENABLE && in_a_q && !in_b_q)
    |=> output_a_oe_o && output_b_oe_o && !output_a_o && output_b_o)
    else $error("Phase/enable state with B low wrong.");

  phase_rev_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (awake_q && !disable_q && active_mode_q == bridge_pkg::MODE_PHASE_ENABLE && in_a_q && in_b_q)
    |=> output_a_oe_o && output_b_oe_o && output_a_o && !output_b_o)
    else $error("Phase/enable state with B high wrong.");

  pwm_float_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (awake_q && !disable_q && active_mode_q == bridge_pkg::MODE_PWM && !in_a_q && !in_b_q)
    |=> !output_a_oe_o && !output_b_oe_o)
    else $error("PWM float state wrong.");

  pwm_fwd_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (awake_q && !disable_q && active_mode_q == bridge_pkg::MODE_PWM && in_a_q && !in_b_q)
    |=> output_a_oe_o && output_b_oe_o && output_a_o && !output_b_o)
    else $error("PWM state with only A high wrong.");

  pwm_rev_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (awake_q && !disable_q && active_mode_q == bridge_pkg::MODE_PWM && !in_a_q && in_b_q)
    |=> output_a_oe_o && output_b_oe_o && !output_a_o && output_b_o)
    else $error("PWM state with only B high wrong.");

  indep_follow_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (awake_q && !disable_q && active_mode_q == bridge_pkg::MODE_INDEPENDENT && trip_q == 2'h0
     && hiz_eff == 2'h0) |=> output_a_oe_o && output_b_oe_o && output_a_o == $past(in_a_q)
     && output_b_o == $past(in_b_q))
    else $error("Independent outputs do not follow inputs.");

  trip_b_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (awake_q && !disable_q && active_mode_q == bridge_pkg::MODE_INDEPENDENT && trip_q == 2'h2
     && !hiz_eff[0]) |=> !output_b_oe_o && output_a_oe_o && output_a_o == $past(in_a_q))
    else $error("Trip isolation on B wrong.");

  hiz_a_bit_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (awake_q && !disable_q && active_mode_q == bridge_pkg::MODE_INDEPENDENT && !strap_var_q
     && hiz_bits_q[0]) |=> !output_a_oe_o)
    else $error("Output A driven although its release bit is set.");

  hiz_b_bit_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (awake_q && !disable_q && active_mode_q == bridge_pkg::MODE_INDEPENDENT && !strap_var_q
     && hiz_bits_q[1]) |=> !output_b_oe_o)
    else $error("Output B driven although its release bit is set.");

  strap_no_hiz_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (awake_q && !disable_q && active_mode_q == bridge_pkg::MODE_INDEPENDENT && strap_var_q
     && trip_q == 2'h0) |=> output_a_oe_o && output_b_oe_o)
    else $error("Strap variant released a single output.");

  strap_low_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (strap_var_q && strap_capture && strap_q == bridge_pkg::STRAP_LOW)
    |=> active_mode_q == bridge_pkg::MODE_PHASE_ENABLE)
    else $error("Strap low decoded wrong.");

  strap_high_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (strap_var_q && strap_capture && strap_q == bridge_pkg::STRAP_HIGH)
    |=> active_mode_q == bridge_pkg::MODE_PWM)
    else $error("Strap high decoded wrong.");

  strap_res_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (strap_var_q && strap_capture && strap_q[1])
    |=> active_mode_q == bridge_pkg::MODE_INDEPENDENT)
    else $error("Strap resistor decoded wrong.");

  sleep_capture_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (strap_var_q && supply_q && awake_q && !awake_prev_q) |-> strap_capture)
    else $error("Strap not captured on sleep exit.");

  field_write_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (reg_write_i && reg_addr_i == bridge_pkg::ADDR_FIRST_CTRL)
    |=> mode_field_q == $past(reg_wdata_i[bridge_pkg::MODE_LSB +: 2]))
    else $error("Mode field write lost.");

  hiz_write_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (reg_write_i && reg_addr_i == bridge_pkg::ADDR_THIRD_CTRL)
    |=> hiz_bits_q == $past({reg_wdata_i[bridge_pkg::HIZ_B_BIT], reg_wdata_i[bridge_pkg::HIZ_A_BIT]}))
    else $error("Release bit write lost.");

  field_read_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (reg_read_i && reg_addr_i == bridge_pkg::ADDR_FIRST_CTRL)
    |=> reg_rdata_o == {6'h00, $past(mode_field_q)})
    else $error("Mode field read wrong.");

  hiz_read_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (reg_read_i && reg_addr_i == bridge_pkg::ADDR_THIRD_CTRL)
    |=> reg_rdata_o == {6'h00, $past(hiz_bits_q)})
    else $error("Release bits read wrong.");

  status_read_a: assert property (@(posedge clk_i) disable iff (!rst_sync_q)
    (reg_read_i && reg_addr_i == bridge_pkg::ADDR_STATUS)
    |=> reg_rdata_o == {6'h00, $past(active_mode_q)})
    else $error("Active mode read wrong.");

endmodule : bridge_control

// ---- bridge_pkg.sv ----
package bridge_pkg;

  typedef enum logic [1:0] {
    MODE_PHASE_ENABLE = 2'h0,
    MODE_PWM          = 2'h1,
    MODE_INDEPENDENT  = 2'h2,
    MODE_INPUTS_OFF   = 2'h3
  } mode_t;

  typedef enum logic [1:0] {
    STRAP_LOW  = 2'h0,
    STRAP_HIGH = 2'h1,
    STRAP_RES  = 2'h2
  } strap_t;

  localparam logic [3:0] ADDR_FIRST_CTRL  = 4'h1;
  localparam logic [3:0] ADDR_THIRD_CTRL  = 4'h3;
  localparam logic [3:0] ADDR_STATUS      = 4'h4;
  localparam int         MODE_LSB         = 0;
  localparam int         HIZ_A_BIT        = 0;
  localparam int         HIZ_B_BIT        = 1;
  localparam logic [1:0] MODE_RESET       = 2'h1;
  localparam logic [1:0] HIZ_RESET        = 2'h0;

endpackage : bridge_pkg

// ---- h_bridge_input_mode_control_tb_top.sv ----
`timescale 1ns/1ps
module h_bridge_input_mode_control_tb_top;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        strap_variant_i = 1'b0;
  logic        logic_supply_ok_i = 1'b1;
  logic [1:0]  mode_strap_i = 2'h0;
  logic        low_power_request_n_i = 1'b1;
  logic        disable_i = 1'b1;
  logic        drv_a = 1'b0, drv_b = 1'b0, brake = 1'b0;
  logic        input_a_i, input_b_i;
  logic [1:0]  overcurrent_trip_i = 2'h0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_write_i = 1'b0, reg_read_i = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic        output_a_o, output_a_oe_o, output_b_o, output_b_oe_o;
  logic [1:0]  mode_e = 2'h1, hiz_e = 2'h0;
  logic [15:0] lf = 16'h9AC5;
  int          errors = 0, tests_run = 0;

  motor_ctrl_model ctrl (.clk_i(clk_i), .drive_a_i(drv_a), .drive_b_i(drv_b), .brake_i(brake),
                         .input_a_o(input_a_i), .input_b_o(input_b_i));
  bridge_control uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .strap_variant_i(strap_variant_i),
    .logic_supply_ok_i(logic_supply_ok_i), .mode_strap_i(mode_strap_i),
    .low_power_request_n_i(low_power_request_n_i), .disable_i(disable_i), .input_a_i(input_a_i),
    .input_b_i(input_b_i), .overcurrent_trip_i(overcurrent_trip_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .output_a_o(output_a_o), .output_a_oe_o(output_a_oe_o), .output_b_o(output_b_o), .output_b_oe_o(output_b_oe_o));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr

  // Result is {oe_a, level_a, oe_b, level_b}; in independent mode a released output still shows its input.
  function automatic logic [7:0] exp_out(input logic [1:0] m, input logic sl, dis, a, b, input logic [1:0] hz, tr);
    logic oa, ob;
    oa = ~hz[0] & ~tr[0];
    ob = ~hz[1] & ~tr[1];
    if (!sl || dis || m == 2'h3) return 8'h00;
    case (m)
      2'h0: return !a ? 8'h0F : (b ? 8'h0E : 8'h0B);
      2'h1: return !(a | b) ? 8'h00 : (a & b ? 8'h0F : (a ? 8'h0E : 8'h0B));
      default: return {4'h0, oa, a, ob, b};
    endcase
  endfunction : exp_out

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    #1;
    check("register", reg_rdata_o, e);
  endtask : rd_chk

  // Six cycles cover the partner flop, two sync flops, the output flop and a disable-fall latch.
  task automatic pins(input logic sl, dis, a, b, br, input logic [1:0] tr);
    logic [7:0] e;
    @(posedge clk_i);
    low_power_request_n_i <= sl;
    disable_i             <= dis;
    drv_a                 <= a;
    drv_b                 <= b;
    brake                 <= br;
    overcurrent_trip_i    <= tr;
    tick(6);
    #1;
    e = exp_out(mode_e, sl, dis, a | br, b | br, hiz_e & {2{~strap_variant_i}}, tr);
    check("outputs", {4'h0, output_a_oe_o, output_a_o, output_b_oe_o, output_b_o}, e);
  endtask : pins

  task automatic latch_mode(input logic [1:0] m);
    reg_wr(bridge_pkg::ADDR_FIRST_CTRL, {6'h00, m});
    pins(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
    mode_e = m;
    pins(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
    rd_chk(bridge_pkg::ADDR_STATUS, {6'h00, m});
  endtask : latch_mode

  task automatic tally_and_finish();
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end

  initial begin
    tick(10);
    reset_n_i <= 1'b1;
    tick(4);
    rd_chk(bridge_pkg::ADDR_FIRST_CTRL, 8'h01);
    rd_chk(bridge_pkg::ADDR_THIRD_CTRL, 8'h00);
    rd_chk(bridge_pkg::ADDR_STATUS, 8'h01);
    rd_chk(4'hF, 8'h00);
    for (int m = 0; m < 4; m++) begin
      latch_mode(m[1:0]);
      for (int i = 0; i < 12; i++) begin
        lf = lfsr(lf);
        pins(lf[0] | lf[1], lf[2] & lf[3], lf[4], lf[5], lf[10] & lf[11], lf[6] ? lf[9:8] : 2'h0);
      end
    end
    latch_mode(2'h2);
    reg_wr(bridge_pkg::ADDR_FIRST_CTRL, 8'h00);
    tick(8);
    rd_chk(bridge_pkg::ADDR_STATUS, 8'h02);
    rd_chk(bridge_pkg::ADDR_FIRST_CTRL, 8'h00);
    for (int h = 1; h < 4; h++) begin
      reg_wr(bridge_pkg::ADDR_THIRD_CTRL, h[7:0]);
      hiz_e = h[1:0];
      rd_chk(bridge_pkg::ADDR_THIRD_CTRL, h[7:0]);
      pins(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0);
    end
    reset_n_i         <= 1'b0;
    strap_variant_i   <= 1'b1;
    logic_supply_ok_i <= 1'b0;
    mode_strap_i      <= 2'h2;
    tick(10);
    reset_n_i    <= 1'b1;
    tick(4);
    rd_chk(bridge_pkg::ADDR_STATUS, 8'h01);
    mode_strap_i <= 2'h0;
    tick(4);
    logic_supply_ok_i <= 1'b1;
    tick(8);
    rd_chk(bridge_pkg::ADDR_STATUS, 8'h00);
    mode_strap_i <= 2'h1;
    tick(8);
    rd_chk(bridge_pkg::ADDR_STATUS, 8'h00);
    for (int v = 1; v < 4; v++) begin
      mode_strap_i <= v[1:0];
      pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0);
      mode_e = v[1] ? 2'h2 : v[1:0];
      pins(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0);
      rd_chk(bridge_pkg::ADDR_STATUS, {6'h00, mode_e});
    end
    reg_wr(bridge_pkg::ADDR_THIRD_CTRL, 8'h03);
    hiz_e = 2'h3;
    pins(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0);
    tally_and_finish();
  end
endmodule : h_bridge_input_mode_control_tb_top

// ---- motor_ctrl_model.sv ----
`timescale 1ns/1ps
module motor_ctrl_model (
  input  wire logic clk_i,
  input  wire logic drive_a_i,
  input  wire logic drive_b_i,
  input  wire logic brake_i,
  output logic      input_a_o,
  output logic      input_b_o
);
  // Braking in the off part keeps the winding clamped rather than floating.
  always_ff @(posedge clk_i) begin
    input_a_o <= brake_i | drive_a_i;
    input_b_o <= brake_i | drive_b_i;
  end
endmodule : motor_ctrl_model

// ---- output_decode.sv ----
`timescale 1ns/1ps
module output_decode (
  input  wire logic [1:0] mode_i,
  input  wire logic       awake_i,
  input  wire logic       disable_i,
  input  wire logic       input_a_i,
  input  wire logic       input_b_i,
  input  wire logic [1:0] hiz_bits_i,
  input  wire logic [1:0] trip_i,
  output logic      [1:0] level_o,
  output logic      [1:0] drive_o
);

  always_comb begin
    level_o = 2'h0;
    drive_o = 2'h0;
    if (awake_i && !disable_i) begin
      unique case (mode_i)
        bridge_pkg::MODE_PHASE_ENABLE: begin
          drive_o = 2'h3;
          if (!input_a_i) begin
            level_o = 2'h3;
          end else begin
            level_o = {~input_b_i, input_b_i};
          end
        end
        bridge_pkg::MODE_PWM: begin
          drive_o = {2{input_a_i | input_b_i}};
          level_o = {input_b_i, input_a_i};
        end
        bridge_pkg::MODE_INDEPENDENT: begin
          level_o = {input_b_i, input_a_i};
          drive_o = ~hiz_bits_i & ~trip_i;
        end
        bridge_pkg::MODE_INPUTS_OFF: begin
          drive_o = 2'h0;
        end
      endcase
    end
  end

endmodule : output_decode
